//--- verilog/supervision_regs.svh
// Purpose: Register offsets, field positions, reset values and count widths
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: Delay registers count clock cycles of aclk (40 ns each)
`ifndef SUPERVISION_REGS_SVH
`define SUPERVISION_REGS_SVH

// Register word indices (byte address divided by four)
`define OFS_TRIP_TERMS 4'h0
`define OFS_TORQUE_CTRL 4'h1
`define OFS_LOAD_DLY 4'h2
`define OFS_CLOSED_PU 4'h3
`define OFS_CLOSED_DO 4'h4
`define OFS_RES_TIME_DLY 4'h5
`define OFS_RES_DEF_DLY 4'h6
`define OFS_STATUS 4'h7
`define ADDR_LSB 2
`define ADDR_MSB 5

// Trip term enable bits
`define TERM_LOW_LOAD 0
`define TERM_LOW_CLOSED 1
`define TERM_RES_PERM5 2
`define TERM_RES_BLOCK5 3
`define TERM_RES_PERM6 4
`define TERM_RES_BLOCK6 5
`define TERM_RES_TIMED 6
`define TERM_RES_INST 7
`define TERM_RES_DEF 8
`define TERM_WIDTH 9

// Torque control bits
`define TC_ASSIGNED 0
`define TC_INVERTED 1
`define TC_SEL_TIMED 2
`define TC_SEL_INST 3
`define TC_SEL_DEF 4
`define TC_WIDTH 5

// Reset values
`define RST_TERMS 9'h000
`define RST_TORQUE 5'h00
`define RST_DELAY 16'h0000
`define DLY_WIDTH 16

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- verilog/supervision_pkg.sv
// Purpose: Types shared by the supervision block
// Assumes: Constants come from supervision_regs.svh
// Notes: All state of the top is one packed struct
`include "supervision_regs.svh"

package supervision_pkg;

	typedef logic [`DLY_WIDTH-1:0] delay_t;

	// Whole state of one qualifying timer
	typedef struct packed {
		delay_t count;
		logic out_bit;
		logic out_bit_n;
	} timer_s;

	// Measured element bits entering the block
	typedef struct packed {
		logic low_set_phase_element;
		logic load_current_detector;
		logic breaker_aux_closed;
		logic residual_timed_pickup;
		logic residual_inst_pickup;
		logic residual_def_pickup;
	} elements_s;

	// Physical control inputs
	typedef struct packed {
		logic input_four;
		logic input_five;
		logic input_six;
	} inputs_s;

	// Software settings
	typedef struct packed {
		logic [`TERM_WIDTH-1:0] terms;
		logic [`TC_WIDTH-1:0] torque;
		delay_t load_detect_pickup_delay;
		delay_t closed_pickup_delay;
		delay_t closed_dropout_delay;
		delay_t res_time_delay;
		delay_t res_def_delay;
	} settings_s;

	// Whole state of the top module
	typedef struct packed {
		settings_s cfg;
		logic aw_held;
		logic [3:0] aw_index;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic protective_open_request;
		logic residual_inst_gated;
	} state_s;

endpackage

//--- verilog/pickup_dropout_timer.sv
// Purpose: Pickup and dropout qualified timer for one logic bit
// Assumes: Delays counted in aclk cycles; zero means one cycle latency
// Notes: Any break in the input restarts the pickup count
`timescale 1ns/1ps
`include "supervision_regs.svh"
module pickup_dropout_timer
	import supervision_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Settings
	input wire delay_t pickup_delay,
	input wire delay_t dropout_delay,
	// Bit to qualify and qualified result
	input wire logic in_bit,
	output logic out_bit,
	output logic out_bit_n
);

	timer_s state;
	timer_s next_state;

	// Count while the input disagrees with the output, restart on agreement
	always_comb begin
		next_state = state;
		if (in_bit == state.out_bit) begin
			next_state.count = `RST_DELAY;
		end else if (in_bit && state.count >= pickup_delay) begin
			next_state.count = `RST_DELAY;
			next_state.out_bit = 1'b1;
			next_state.out_bit_n = 1'b0;
		end else if (!in_bit && state.count >= dropout_delay) begin
			next_state.count = `RST_DELAY;
			next_state.out_bit = 1'b0;
			next_state.out_bit_n = 1'b1;
		end else begin
			next_state.count = state.count + 1'b1;
		end
	end

	// State register, output idle low and its inverse high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state.count <= `RST_DELAY;
			state.out_bit <= 1'b0;
			state.out_bit_n <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// Both senses come from their own flops
	assign out_bit = state.out_bit;
	assign out_bit_n = state.out_bit_n;

endmodule

//--- verilog/trip_supervision.sv
// Purpose: Cold load blocking and ground element disabling for the trip contacts
// Assumes: Element bits and inputs are synchronous to aclk; AXI4-Lite registers
// Notes: Trip contact closes one cycle after its terms become true
`timescale 1ns/1ps
`include "supervision_regs.svh"

module trip_supervision
	import supervision_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Measured elements and control inputs
	input wire elements_s elements,
	input wire inputs_s inputs,
	// Trip contact and supervision bits
	output logic protective_open_request,
	output logic delayed_load_detect,
	output logic breaker_closed_timed,
	output logic breaker_open_timed,
	output logic residual_timed_element,
	output logic residual_def_element,
	output logic residual_inst_gated
);

	state_s state;
	state_s next_state;
	logic torque_enable;
	logic [2:0] pickup_raw;
	logic [2:0] pickup_sel;
	logic [2:0] pickup_gated;
	logic res_timed_gated;
	logic res_def_gated;
	logic res_inst_gated;
	logic [`TERM_WIDTH-1:0] term;
	logic [31:0] status;

	// External torque control level from input four, either sense
	always_comb begin
		if (!state.cfg.torque[`TC_ASSIGNED]) begin
			torque_enable = 1'b1;
		end else if (state.cfg.torque[`TC_INVERTED]) begin
			torque_enable = !inputs.input_four;
		end else begin
			torque_enable = inputs.input_four;
		end
	end

	// Pickups and their selection bits, one order: timed, inst, def
	assign pickup_raw = {elements.residual_timed_pickup, elements.residual_inst_pickup,
		elements.residual_def_pickup};
	assign pickup_sel = {state.cfg.torque[`TC_SEL_TIMED], state.cfg.torque[`TC_SEL_INST],
		state.cfg.torque[`TC_SEL_DEF]};

	// Only pickups named in the selection see the torque gate
	for (genvar g = 0; g < 3; g++) begin : gen_torque
		assign pickup_gated[g] = pickup_raw[g] && (torque_enable || !pickup_sel[g]);
	end

	// Gated pickups by name
	assign res_timed_gated = pickup_gated[2];
	assign res_inst_gated = pickup_gated[1];
	assign res_def_gated = pickup_gated[0];

	// Load detector qualified by its pickup delay, no dropout delay
	pickup_dropout_timer load_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.pickup_delay(state.cfg.load_detect_pickup_delay),
		.dropout_delay(`RST_DELAY),
		.in_bit(elements.load_current_detector),
		.out_bit(delayed_load_detect),
		.out_bit_n()
	);

	// Breaker auxiliary contact qualified by pickup and dropout delays
	pickup_dropout_timer closed_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.pickup_delay(state.cfg.closed_pickup_delay),
		.dropout_delay(state.cfg.closed_dropout_delay),
		.in_bit(elements.breaker_aux_closed),
		.out_bit(breaker_closed_timed),
		.out_bit_n(breaker_open_timed)
	);

	// Residual time element only times while its gated pickup holds
	pickup_dropout_timer res_time_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.pickup_delay(state.cfg.res_time_delay),
		.dropout_delay(`RST_DELAY),
		.in_bit(res_timed_gated),
		.out_bit(residual_timed_element),
		.out_bit_n()
	);

	// Residual definite-time element, same gating idea
	pickup_dropout_timer res_def_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.pickup_delay(state.cfg.res_def_delay),
		.dropout_delay(`RST_DELAY),
		.in_bit(res_def_gated),
		.out_bit(residual_def_element),
		.out_bit_n()
	);

	// Low-set and residual input terms are an element ANDed with a supervising bit; the last three are the residual elements alone
	always_comb begin
		term = '0;
		term[`TERM_LOW_LOAD] = elements.low_set_phase_element
			&& delayed_load_detect;
		term[`TERM_LOW_CLOSED] = elements.low_set_phase_element
			&& breaker_closed_timed;
		term[`TERM_RES_PERM5] = residual_timed_element && inputs.input_five;
		term[`TERM_RES_BLOCK5] = residual_timed_element && !inputs.input_five;
		term[`TERM_RES_PERM6] = residual_timed_element && inputs.input_six;
		term[`TERM_RES_BLOCK6] = residual_timed_element && !inputs.input_six;
		term[`TERM_RES_TIMED] = residual_timed_element;
		term[`TERM_RES_INST] = res_inst_gated;
		term[`TERM_RES_DEF] = residual_def_element;
	end

	// Live state for software
	always_comb begin
		status = '0;
		status[0] = delayed_load_detect;
		status[1] = breaker_closed_timed;
		status[2] = breaker_open_timed;
		status[3] = residual_timed_element;
		status[4] = residual_def_element;
		status[5] = state.residual_inst_gated;
		status[6] = state.protective_open_request;
		status[7] = torque_enable;
		status[8] = inputs.input_four;
		status[9] = inputs.input_five;
		status[10] = inputs.input_six;
		status[11] = elements.load_current_detector;
		status[12] = elements.breaker_aux_closed;
	end

	// Bus slave, settings and trip output
	always_comb begin
		logic [3:0] ridx;
		logic mapped;
		logic [31:0] word;
		ridx = s_axi_araddr[`ADDR_MSB:`ADDR_LSB];
		mapped = 1'b0;
		word = '0;
		next_state = state;
		next_state.awready = 1'b0;
		next_state.wready = 1'b0;
		next_state.arready = 1'b0;

		// Trip contact closes whenever any enabled term is true
		next_state.protective_open_request = |(term & state.cfg.terms);
		next_state.residual_inst_gated = res_inst_gated;

		// Write address and data taken in either order
		if (s_axi_awvalid && !state.aw_held && !state.awready && !state.bvalid) begin
			next_state.awready = 1'b1;
			next_state.aw_held = 1'b1;
			next_state.aw_index = s_axi_awaddr[`ADDR_MSB:`ADDR_LSB];
			if (|s_axi_awaddr[31:`ADDR_MSB+1] || |s_axi_awaddr[1:0]) begin
				next_state.aw_index = 4'hF;
			end
		end
		if (s_axi_wvalid && !state.w_held && !state.wready && !state.bvalid) begin
			next_state.wready = 1'b1;
			next_state.w_held = 1'b1;
			next_state.wdata = s_axi_wdata;
			next_state.wstrb = s_axi_wstrb;
		end

		// Commit the write once both halves are held
		if (state.aw_held && state.w_held && !state.bvalid) begin
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = `RESP_OKAY;
			word = state.wdata;
			for (int i = 0; i < 4; i++) begin
				if (!state.wstrb[i]) begin
					word[8*i +: 8] = 8'h00;
				end
			end
			case (state.aw_index)
				// Nine term enables across lanes zero and one
				`OFS_TRIP_TERMS: begin
					if (state.wstrb[0]) next_state.cfg.terms[7:0] = word[7:0];
					if (state.wstrb[1]) next_state.cfg.terms[8] = word[8];
				end
				// Torque control lives in lane zero
				`OFS_TORQUE_CTRL: begin
					if (state.wstrb[0]) next_state.cfg.torque = word[`TC_WIDTH-1:0];
				end
				// Delay settings take lanes zero and one
				`OFS_LOAD_DLY: begin
					next_state.cfg.load_detect_pickup_delay =
						merge(state.cfg.load_detect_pickup_delay, word, state.wstrb);
				end
				`OFS_CLOSED_PU: begin
					next_state.cfg.closed_pickup_delay =
						merge(state.cfg.closed_pickup_delay, word, state.wstrb);
				end
				`OFS_CLOSED_DO: begin
					next_state.cfg.closed_dropout_delay =
						merge(state.cfg.closed_dropout_delay, word, state.wstrb);
				end
				`OFS_RES_TIME_DLY: begin
					next_state.cfg.res_time_delay =
						merge(state.cfg.res_time_delay, word, state.wstrb);
				end
				`OFS_RES_DEF_DLY: begin
					next_state.cfg.res_def_delay =
						merge(state.cfg.res_def_delay, word, state.wstrb);
				end
				// Status is live state, nothing to store
				`OFS_STATUS: begin
					next_state.bresp = `RESP_OKAY; // Read-only, write ignored
				end
				// Unmapped or unaligned places are refused
				default: begin
					next_state.bresp = `RESP_SLVERR;
				end
			endcase
		end
		// Response handshake ends the write
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
		end

		// Read: take the address, answer on the next edge
		if (s_axi_arvalid && !state.arready && !state.rvalid) begin
			next_state.arready = 1'b1;
			next_state.rvalid = 1'b1;
			mapped = !(|s_axi_araddr[31:`ADDR_MSB+1]) && !(|s_axi_araddr[1:0]);
			case (ridx)
				`OFS_TRIP_TERMS: word = 32'(state.cfg.terms);
				`OFS_TORQUE_CTRL: word = 32'(state.cfg.torque);
				`OFS_LOAD_DLY: word = 32'(state.cfg.load_detect_pickup_delay);
				`OFS_CLOSED_PU: word = 32'(state.cfg.closed_pickup_delay);
				`OFS_CLOSED_DO: word = 32'(state.cfg.closed_dropout_delay);
				`OFS_RES_TIME_DLY: word = 32'(state.cfg.res_time_delay);
				`OFS_RES_DEF_DLY: word = 32'(state.cfg.res_def_delay);
				`OFS_STATUS: word = status;
				default: mapped = 1'b0;
			endcase
			// Refused reads carry zero data
			next_state.rdata = mapped ? word : 32'h00000000;
			next_state.rresp = mapped ? `RESP_OKAY : `RESP_SLVERR;
		end
		// Read data leaves on its handshake
		if (state.rvalid && s_axi_rready) begin
			next_state.rvalid = 1'b0;
		end
	end

	// Byte-lane merge of a 16-bit delay setting
	function automatic delay_t merge(input delay_t old, input logic [31:0] word,
		input logic [3:0] strb);
		delay_t v;
		v = old;
		if (strb[0]) v[7:0] = word[7:0];
		if (strb[1]) v[15:8] = word[15:8];
		return v;
	endfunction

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Handshakes and trip output idle
			state <= '0;
			// Settings to their reset values
			state.cfg.terms <= `RST_TERMS;
			state.cfg.torque <= `RST_TORQUE;
			state.cfg.load_detect_pickup_delay <= `RST_DELAY;
			state.cfg.closed_pickup_delay <= `RST_DELAY;
			state.cfg.closed_dropout_delay <= `RST_DELAY;
			state.cfg.res_time_delay <= `RST_DELAY;
			state.cfg.res_def_delay <= `RST_DELAY;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from the state flops
	assign s_axi_awready = state.awready;
	assign s_axi_wready = state.wready;
	assign s_axi_bvalid = state.bvalid;
	assign s_axi_bresp = state.bresp;
	assign s_axi_arready = state.arready;
	assign s_axi_rvalid = state.rvalid;
	assign s_axi_rdata = state.rdata;
	assign s_axi_rresp = state.rresp;

	// Trip contact and gated pickup from their flops
	assign protective_open_request = state.protective_open_request;
	assign residual_inst_gated = state.residual_inst_gated;

endmodule

//--- tb/supervision_props.sv
// Purpose: Port checker for the trip supervision block
// Assumes: Trip and timer outputs are registered, one edge after their cause
// Notes: Settings are not visible here, so only cause and effect are tied
`timescale 1ns/1ps
module supervision_props
	import supervision_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Elements and supervision outputs
	input wire elements_s elements,
	input wire logic protective_open_request,
	input wire logic delayed_load_detect,
	input wire logic breaker_closed_timed,
	input wire logic breaker_open_timed,
	input wire logic residual_timed_element,
	input wire logic residual_def_element,
	input wire logic residual_inst_gated
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Steps of a bus transfer
	sequence s_bwait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence s_rwait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	sequence s_wtaken;
		s_axi_awready && s_axi_wready;
	endsequence
	// Supervision relations
	AST_OPEN_INV: assert property (breaker_open_timed != breaker_closed_timed)
		else $error("open indication not inverse of closed");
	AST_LOAD_CLEAR: assert property (!elements.load_current_detector |=> !delayed_load_detect)
		else $error("delayed load detect did not clear");
	AST_LOAD_CAUSE: assert property (delayed_load_detect |-> $past(elements.load_current_detector))
		else $error("delayed load detect without load");
	AST_TRIP_CAUSE: assert property (protective_open_request |-> residual_inst_gated ||
		$past(elements.low_set_phase_element && (delayed_load_detect || breaker_closed_timed)
		|| residual_timed_element || residual_def_element))
		else $error("trip without any gated term");
	AST_INST_GATE: assert property (residual_inst_gated |-> $past(elements.residual_inst_pickup))
		else $error("instantaneous gate without pickup");
	AST_TIMED_GATE: assert property (residual_timed_element |-> $past(elements.residual_timed_pickup))
		else $error("timed element without pickup");
	AST_DEF_GATE: assert property (residual_def_element |-> $past(elements.residual_def_pickup))
		else $error("definite element without pickup");
	AST_CLOSED_CAUSE: assert property ($rose(breaker_closed_timed) |-> $past(elements.breaker_aux_closed))
		else $error("closed indication without breaker");
	AST_BVALID_HOLD: assert property (s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_RVALID_HOLD: assert property (s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_WRESP: assert property (s_wtaken |=> s_axi_bvalid)
		else $error("write response late");
	AST_RD_ANS: assert property ($rose(s_axi_arready) |-> s_axi_rvalid)
		else $error("read answer not with arready");
endmodule

bind trip_supervision supervision_props supervision_props_i (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.elements(elements), .protective_open_request(protective_open_request),
	.delayed_load_detect(delayed_load_detect), .breaker_closed_timed(breaker_closed_timed),
	.breaker_open_timed(breaker_open_timed), .residual_timed_element(residual_timed_element),
	.residual_def_element(residual_def_element), .residual_inst_gated(residual_inst_gated));

//--- tb/breaker_model.sv
// Purpose: Feeder breaker driven by the trip contact
// Assumes: Closes on a rising close command, opens after a held trip
// Notes: Load current is seen only while closed and demand is present
`timescale 1ns/1ps
module breaker_model #(
	parameter int OPEN_DLY = 2
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Operator and trip
	input wire logic close_cmd,
	input wire logic demand,
	input wire logic trip,
	// Breaker state seen by the block
	output logic aux_closed,
	output logic load_seen
);
	logic close_q;
	int cnt;
	// Mechanism opens only after the trip has been held OPEN_DLY edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_closed <= 1'h0;
			close_q <= 1'h0;
			cnt <= 0;
		end else begin
			close_q <= close_cmd;
			cnt <= trip ? cnt + 1 : 0;
			if (trip && cnt == OPEN_DLY - 1)
				aux_closed <= 1'h0;
			else if (close_cmd && !close_q)
				aux_closed <= 1'h1;
		end
	end
	// Load detector follows current flow
	assign load_seen = aux_closed & demand;
endmodule

//--- tb/trip_supervision_tb_top.sv
// Purpose: Self-checking bench for the trip supervision block
// Assumes: Bus tasks follow the AXI4-Lite handshake
// Notes: Expected counts are in aclk cycles from the driving edge
`timescale 1ns/1ps
`include "supervision_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module trip_supervision_tb_top
	import supervision_pkg::*;
;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic arready, rvalid, trip, dld, bct, bot, rte, rde, rig, e;
	logic low_set, p_rt, p_ri, p_rd, close_cmd, demand, aux, load;
	logic [31:0] awaddr, wdata, araddr, rdata, d;
	logic [1:0] bresp, rresp, r;
	inputs_s ins;
	elements_s el;
	int fail_count, comparisons, cycles;
	assign el = {low_set, load, aux, p_rt, p_ri, p_rd};
	trip_supervision trip_supervision_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .elements(el), .inputs(ins), .protective_open_request(trip),
		.delayed_load_detect(dld), .breaker_closed_timed(bct), .breaker_open_timed(bot),
		.residual_timed_element(rte), .residual_def_element(rde), .residual_inst_gated(rig));
	breaker_model breaker_model_i (.aclk(aclk), .aresetn(aresetn), .close_cmd(close_cmd),
		.demand(demand), .trip(trip), .aux_closed(aux), .load_seen(load));
	// Clock
	initial begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end
	// Hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			conclude();
		end
	end
	// Bus write, valids released as each half is taken, bready raised after lag edges
	task automatic wr(input logic [31:0] a, input logic [31:0] dt, input int lag = 0);
		int n;
		logic done;
		n = 0;
		done = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dt;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'(lag == 0);
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			done = bvalid === 1'h1 && bready === 1'h1;
			n++;
			if (!done && n >= lag) bready <= 1'h1;
		end while (!done);
		bready <= 1'h0;
		r = bresp;
	endtask
	// Bus read, rready raised after lag edges
	task automatic rd(input logic [31:0] a, input int lag = 0);
		int n;
		logic done;
		n = 0;
		done = 1'h0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'(lag == 0);
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			done = rvalid === 1'h1 && rready === 1'h1;
			n++;
			if (!done && n >= lag) rready <= 1'h1;
		end while (!done);
		rready <= 1'h0;
		d = rdata;
		r = rresp;
	endtask
	// Output picked by a scenario
	function automatic logic obs(input int s);
		case (s)
			0: return dld;
			1: return trip;
			2: return !trip;
			default: return bct;
		endcase
	endfunction
	// Edges from the driving edge until the picked output goes high
	task automatic rise(input int s, input int x, input string nm);
		int n;
		n = 0;
		#1;
		while (obs(s) !== 1'h1 && n < 60) begin
			@(posedge aclk);
			#1;
			n++;
		end
		`CHK(nm, x, n)
	endtask
	// Verdict
	task automatic conclude();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, low_set} = 7'h00;
		{p_rt, p_ri, p_rd, close_cmd, demand} = 5'h00;
		{awaddr, wdata, araddr, ins} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		// Reset values, masking, unmapped and read-only places
		for (int i = 0; i < 7; i++) begin
			rd(32'(i * 4));
			`CHK("setting reset", 32'h0, d)
		end
		rd(`OFS_STATUS * 4);
		`CHK("open after reset", 1'h1, d[2])
		wr(`OFS_TRIP_TERMS * 4, 32'hFFFFFFFF);
		rd(`OFS_TRIP_TERMS * 4);
		`CHK("term width", 32'h1FF, d)
		rd(32'h20, 3);
		`CHK("unmapped resp", `RESP_SLVERR, r)
		`CHK("unmapped data", 32'h0, d)
		wr(`OFS_STATUS * 4, 32'h0, 3);
		`CHK("status write", `RESP_OKAY, r)
		wr(32'h22, 32'h0);
		`CHK("unaligned write resp", `RESP_SLVERR, r)
		// Low-set held off by delayed load detect, then breaker opens
		wr(`OFS_LOAD_DLY * 4, 32'h3);
		wr(`OFS_TRIP_TERMS * 4, 32'h1);
		@(posedge aclk);
		low_set <= 1'h1;
		demand <= 1'h1;
		close_cmd <= 1'h1;
		rise(1, 6, "load gated trip");
		rise(2, 4, "trip clears");
		`CHK("breaker opened", 1'h0, aux)
		// Low-set held off by timed closed indication
		wr(`OFS_CLOSED_PU * 4, 32'h5);
		wr(`OFS_CLOSED_DO * 4, 32'h2);
		wr(`OFS_TRIP_TERMS * 4, 32'h2);
		@(posedge aclk);
		demand <= 1'h0;
		close_cmd <= 1'h0;
		@(posedge aclk);
		close_cmd <= 1'h1;
		rise(1, 8, "closed gated trip");
		`CHK("open inverse", 1'h0, bot)
		rise(2, 6, "closed dropout");
		// Load detect restarts after a break
		wr(`OFS_TRIP_TERMS * 4, 32'h0);
		low_set <= 1'h0;
		close_cmd <= 1'h0;
		@(posedge aclk);
		close_cmd <= 1'h1;
		repeat (2) @(posedge aclk);
		demand <= 1'h1;
		repeat (2) @(posedge aclk);
		demand <= 1'h0;
		@(posedge aclk);
		demand <= 1'h1;
		rise(0, 4, "load restart");
		// Permissive and block terms on inputs five and six
		@(posedge aclk);
		demand <= 1'h0;
		p_rt <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			for (int v = 0; v < 2; v++) begin
				wr(`OFS_TRIP_TERMS * 4, 32'h4 << i);
				ins <= {1'h0, 1'(v), 1'(v)};
				repeat (4) @(posedge aclk);
				#1;
				`CHK("supervised trip", 1'((v + i) % 2), trip)
			end
		end
		// Torque control, plain and inverted; load detector never selected
		wr(`OFS_TRIP_TERMS * 4, 32'h1C0);
		p_ri <= 1'h1;
		p_rd <= 1'h1;
		for (int m = 0; m < 3; m++) begin
			for (int k = 0; k < 4; k++) begin
				wr(`OFS_TORQUE_CTRL * 4, 32'h1 | (32'(k / 2) << 1) | (32'h4 << m));
				ins <= {1'(k % 2), 2'h0};
				repeat (4) @(posedge aclk);
				#1;
				e = 1'((k % 2) ^ (k / 2));
				`CHK("torque timed", m == 0 ? e : 1'h1, rte)
				`CHK("torque inst", m == 1 ? e : 1'h1, rig)
				`CHK("torque def", m == 2 ? e : 1'h1, rde)
			end
		end
		// Inputs five and six visible as bits
		@(posedge aclk);
		ins <= 3'h2;
		rd(`OFS_STATUS * 4);
		`CHK("input bits", 2'h1, d[10:9])
		conclude();
	end
endmodule
